// >>> hw/spibfc_pkg.sv
// Package: register map, field positions and timing for the SPI buffer flags block
package spibfc_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_STAT = 8'h00;
    localparam logic [7:0] ADDR_CON1 = 8'h04;
    localparam logic [7:0] ADDR_BUF = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    // ****************************************
    // Status fields
    // ****************************************
    localparam int STAT_RBF = 0;
    localparam int STAT_TBF = 1;
    localparam int STAT_TXCNT_LSB = 8;
    localparam int STAT_RXCNT_LSB = 12;
    // ****************************************
    // Control one fields
    // ****************************************
    localparam int CON1_PPRE_LSB = 0;
    localparam int CON1_SPRE_LSB = 2;
    localparam int CON1_MASTER_MODE_ENABLE = 5;
    localparam int CON1_CKP = 6;
    localparam int CON1_SLAVE_SELECT_PIN_ENABLE = 7;
    localparam int CON1_CKE = 8;
    localparam int CON1_SMP = 9;
    localparam int CON1_WORD_WIDTH_SELECT = 10;
    localparam int CON1_DATA_OUT_PIN_DISABLE = 11;
    localparam int CON1_CLOCK_PIN_DISABLE = 12;
    localparam logic [15:0] CON1_WMASK = 16'h1FFF;
    localparam logic [15:0] CON1_RESET = 16'h0000;
    // ****************************************
    // Extra control fields
    // ****************************************
    localparam int CTRL_PORT_EN = 0;
    localparam int CTRL_ENH = 1;
    // ****************************************
    // Interrupt events
    // ****************************************
    localparam int IRQ_TX_FREE = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_RX_OVF = 2;
    localparam int IRQ_W = 3;
    // ****************************************
    // Timing
    // ****************************************
    localparam int SYNC_STAGES = 2;
    localparam int ENH_DEPTH = 4;
endpackage : spibfc_pkg

// >>> hw/spibfc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spibfc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;
    // ****************************************
    // First stage read only by second
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule : spibfc_sync
`default_nettype wire

// >>> hw/spibfc_top.sv
// SPI port with buffer-full flags, control register and APB slave
// Operation
// - Standard mode: CPU write of data buffer sets transmit-full flag
// - Standard mode: move to shift register clears transmit-full flag
// - Enhanced mode: transmit-full set when write fills last free entry
// - Enhanced mode: transmit-full clears once an entry is free
// - Standard mode: received word into holding buffer sets receive-full
// - Standard mode: CPU read of data buffer clears receive-full
// - Enhanced mode: receive-full set when last unread entry fills
// - Enhanced mode: receive-full clears once an entry is free
// - Status bit 1 is transmit-full, bit 0 receive-full, one means full
// - Master with clock disable set: clock pin released to general I/O
// - Width bit 10: one gives 16-bit, zero 8-bit transfers
// - Master sample phase: one samples at end, zero at middle
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spibfc_top #(
    parameter int DEPTH = spibfc_pkg::ENH_DEPTH,
    parameter int HALF_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic ss_n_in,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [15:0] con1;
        logic [1:0] ctrl;
        logic [DEPTH-1:0][15:0] txm;
        logic [PW-1:0] tx_wp;
        logic [PW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic [DEPTH-1:0][15:0] rxm;
        logic [PW-1:0] rx_wp;
        logic [PW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        logic tbf;
        logic rbf;
        logic [15:0] sr;
        logic busy;
        logic [4:0] bits;
        logic [7:0] div;
        logic sck;
        logic sdo;
        logic sdi_lat;
        logic sck_prev;
        logic [spibfc_pkg::IRQ_W-1:0] ist;
        logic [spibfc_pkg::IRQ_W-1:0] ien;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic sck_oe_n;
        logic sdo_oe_n;
    } spibfc_state_s;

    spibfc_state_s s_q;
    spibfc_state_s s_d;
    logic sck_s;
    logic sdi_s;
    logic ss_n_s;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    spibfc_sync u_sync_sck (.pclk(pclk), .presetn(presetn), .din(sck_in), .dout(sck_s));
    spibfc_sync u_sync_sdi (.pclk(pclk), .presetn(presetn), .din(sdi), .dout(sdi_s));
    spibfc_sync u_sync_ss (.pclk(pclk), .presetn(presetn), .din(ss_n_in), .dout(ss_n_s));

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic wr;
        logic rd;
        logic buf_wr;
        logic buf_rd;
        logic enh;
        logic en;
        logic master;
        logic m16;
        logic cke;
        logic ckp;
        logic lead;
        logic trail;
        logic shift_edge;
        logic samp_edge;
        logic load_sr;
        logic done;
        logic [15:0] rxword;
        logic [CW-1:0] depth_c;
        logic [spibfc_pkg::IRQ_W-1:0] ev;
        logic [spibfc_pkg::IRQ_W-1:0] clr;
        s_d = s_q;
        wr = psel && penable && pwrite && !s_q.pready;
        rd = psel && penable && !pwrite && !s_q.pready;
        buf_wr = wr && (paddr == spibfc_pkg::ADDR_BUF);
        buf_rd = rd && (paddr == spibfc_pkg::ADDR_BUF);
        enh = s_q.ctrl[spibfc_pkg::CTRL_ENH];
        en = s_q.ctrl[spibfc_pkg::CTRL_PORT_EN];
        master = s_q.con1[spibfc_pkg::CON1_MASTER_MODE_ENABLE];
        m16 = s_q.con1[spibfc_pkg::CON1_WORD_WIDTH_SELECT];
        cke = s_q.con1[spibfc_pkg::CON1_CKE];
        ckp = s_q.con1[spibfc_pkg::CON1_CKP];
        depth_c = enh ? CW'(DEPTH) : CW'(1);
        lead = 1'b0;
        trail = 1'b0;
        load_sr = 1'b0;
        done = 1'b0;
        ev = '0;
        clr = '0;
        rxword = '0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // ****************************************
        // APB access, one wait state
        // ****************************************
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
            case (paddr)
                spibfc_pkg::ADDR_STAT: begin
                    s_d.prdata[spibfc_pkg::STAT_TBF] = s_q.tbf;
                    s_d.prdata[spibfc_pkg::STAT_RBF] = s_q.rbf;
                    s_d.prdata[spibfc_pkg::STAT_TXCNT_LSB +: CW] = s_q.tx_cnt;
                    s_d.prdata[spibfc_pkg::STAT_RXCNT_LSB +: CW] = s_q.rx_cnt;
                end
                spibfc_pkg::ADDR_CON1: begin
                    s_d.prdata[15:0] = s_q.con1;
                    if (pwrite) begin
                        s_d.con1 = pwdata[15:0] & spibfc_pkg::CON1_WMASK;
                    end
                end
                spibfc_pkg::ADDR_BUF: begin
                    s_d.prdata[15:0] = s_q.rxm[s_q.rx_rp];
                end
                spibfc_pkg::ADDR_CTRL: begin
                    s_d.prdata[1:0] = s_q.ctrl;
                    if (pwrite) begin
                        s_d.ctrl = pwdata[1:0];
                    end
                end
                spibfc_pkg::ADDR_IRQ_STAT: begin
                    s_d.prdata[spibfc_pkg::IRQ_W-1:0] = s_q.ist;
                end
                spibfc_pkg::ADDR_IRQ_EN: begin
                    s_d.prdata[spibfc_pkg::IRQ_W-1:0] = s_q.ien;
                    if (pwrite) begin
                        s_d.ien = pwdata[spibfc_pkg::IRQ_W-1:0];
                    end
                end
                spibfc_pkg::ADDR_IRQ_CLR: begin
                    if (pwrite) begin
                        clr = pwdata[spibfc_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // ****************************************
        // Serial clock and shifting
        // ****************************************
        if (master) begin
            if (s_q.busy) begin
                if (s_q.div == 8'(HALF_DIV - 1)) begin
                    s_d.div = '0;
                    s_d.sck = !s_q.sck;
                    lead = (s_q.sck == ckp);
                    trail = !lead;
                end else begin
                    s_d.div = s_q.div + 8'h01;
                end
            end else begin
                s_d.sck = ckp;
                s_d.div = '0;
            end
        end else begin
            s_d.sck = ckp;
            s_d.sck_prev = sck_s;
            if (s_q.busy && !(s_q.con1[spibfc_pkg::CON1_SLAVE_SELECT_PIN_ENABLE] && ss_n_s)) begin
                lead = (sck_s != s_q.sck_prev) && (s_q.sck_prev == ckp);
                trail = (sck_s != s_q.sck_prev) && (s_q.sck_prev != ckp);
            end
        end
        // ****************************************
        // Shift data and bit count
        // ****************************************
        shift_edge = cke ? trail : lead;
        samp_edge = cke ? lead : trail;
        if (master && s_q.con1[spibfc_pkg::CON1_SMP]) begin
            samp_edge = shift_edge;
        end
        if (samp_edge) begin
            s_d.sdi_lat = sdi_s;
            if (!master || !s_q.con1[spibfc_pkg::CON1_SMP]) begin
                s_d.bits = s_q.bits - 5'h01;
            end
        end
        if (shift_edge) begin
            s_d.sr = {s_q.sr[14:0], (master && s_q.con1[spibfc_pkg::CON1_SMP]) ? sdi_s : s_q.sdi_lat};
            s_d.sdo = m16 ? s_d.sr[15] : s_d.sr[7];
            if (master && s_q.con1[spibfc_pkg::CON1_SMP]) begin
                s_d.bits = s_q.bits - 5'h01;
            end
        end
        if (s_q.busy && s_q.bits == 5'h00 && (shift_edge || !master)) begin
            done = 1'b1;
            s_d.busy = 1'b0;
            rxword = m16 ? s_q.sr : {8'h00, s_q.sr[7:0]};
            // Hold the clock, a closing toggle would leave a runt pulse
            if (master) begin
                s_d.sck = s_q.sck;
            end
        end
        // Slave has no gap detection, the word ends on the bit count
        // ****************************************
        // Word load from transmit buffer
        // ****************************************
        if (en && !s_q.busy && s_q.tx_cnt != '0) begin
            load_sr = 1'b1;
            s_d.busy = 1'b1;
            s_d.sr = s_q.txm[s_q.tx_rp];
            s_d.bits = m16 ? 5'h10 : 5'h08;
            s_d.sdo = m16 ? s_q.txm[s_q.tx_rp][15] : s_q.txm[s_q.tx_rp][7];
        end
        if (!en) begin
            s_d.busy = 1'b0;
        end
        // ****************************************
        // Transmit buffer
        // ****************************************
        if (buf_wr && s_q.tx_cnt != depth_c) begin
            s_d.txm[s_q.tx_wp] = pwdata[15:0];
            s_d.tx_wp = enh ? PW'(s_q.tx_wp + 1'b1) : s_q.tx_wp;
        end
        if (load_sr) begin
            s_d.tx_rp = enh ? PW'(s_q.tx_rp + 1'b1) : s_q.tx_rp;
            ev[spibfc_pkg::IRQ_TX_FREE] = 1'b1;
        end
        s_d.tx_cnt = s_q.tx_cnt + CW'(buf_wr && s_q.tx_cnt != depth_c) - CW'(load_sr);
        s_d.tbf = (s_d.tx_cnt == depth_c);
        // ****************************************
        // Receive buffer
        // ****************************************
        if (buf_rd && s_q.rx_cnt != '0) begin
            s_d.rx_rp = enh ? PW'(s_q.rx_rp + 1'b1) : s_q.rx_rp;
        end
        if (done) begin
            if (s_q.rx_cnt != depth_c) begin
                s_d.rxm[s_q.rx_wp] = rxword;
                s_d.rx_wp = enh ? PW'(s_q.rx_wp + 1'b1) : s_q.rx_wp;
                ev[spibfc_pkg::IRQ_RX_DONE] = 1'b1;
            end else begin
                ev[spibfc_pkg::IRQ_RX_OVF] = 1'b1;
            end
        end
        s_d.rx_cnt = s_q.rx_cnt + CW'(done && s_q.rx_cnt != depth_c)
            - CW'(buf_rd && s_q.rx_cnt != '0);
        s_d.rbf = (s_d.rx_cnt == depth_c);
        // ****************************************
        // Mode switch flush
        // ****************************************
        // Only on entry, so leaving enhanced mode keeps unread words
        if (!enh && s_q.ctrl[spibfc_pkg::CTRL_ENH] != s_d.ctrl[spibfc_pkg::CTRL_ENH]) begin
            s_d.tx_wp = '0;
            s_d.tx_rp = '0;
            s_d.rx_wp = '0;
            s_d.rx_rp = '0;
            s_d.tx_cnt = '0;
            s_d.rx_cnt = '0;
            s_d.tbf = 1'b0;
            s_d.rbf = 1'b0;
        end
        // ****************************************
        // Interrupts, set wins over clear
        // ****************************************
        s_d.ist = (s_q.ist & ~clr) | ev;
        s_d.irq = |(s_d.ist & s_d.ien);
        // ****************************************
        // Pin enables, active low
        // ****************************************
        // clock pin drive
        s_d.sck_oe_n = !(en && s_d.con1[spibfc_pkg::CON1_MASTER_MODE_ENABLE]
            && !s_d.con1[spibfc_pkg::CON1_CLOCK_PIN_DISABLE]);
        s_d.sdo_oe_n = !(en && !s_d.con1[spibfc_pkg::CON1_DATA_OUT_PIN_DISABLE]);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.con1 <= spibfc_pkg::CON1_RESET;
            s_q.sck_oe_n <= 1'b1;
            s_q.sdo_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign sck_out = s_q.sck;
    assign sck_oe_n = s_q.sck_oe_n;
    assign sdo = s_q.sdo;
    assign sdo_oe_n = s_q.sdo_oe_n;
    assign irq = s_q.irq;
endmodule : spibfc_top
`default_nettype wire

// >>> tb/spibfc_bench.sv
// Self-checking bench for buffer flags, control register and interrupts
`timescale 1ns/1ps
`default_nettype none
module spibfc_bench;
    // ****
    // Signals and instances
    // ****
    localparam logic [7:0] STAT = spibfc_pkg::ADDR_STAT;
    localparam logic [7:0] CON1 = spibfc_pkg::ADDR_CON1;
    localparam logic [7:0] BUF = spibfc_pkg::ADDR_BUF;
    localparam logic [7:0] CTRL = spibfc_pkg::ADDR_CTRL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, ss_n_in = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [4:0] nbits = 5'h08;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, sck_in, sck_out, sck_oe_n, sdi, sdo, sdo_oe_n, irq;
    int bad_count = 0, compares = 0;
    always #25 pclk = ~pclk;
    spibfc_top #(.DEPTH(4), .HALF_DIV(4)) spibfc_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .ss_n_in(ss_n_in), .irq(irq));
    spibfc_peer spibfc_peer_i (.go(go), .nbits(nbits), .sel_n(ss_n_in), .mclk(sck_out),
        .sck(sck_in), .sdi(sdi));
    // ****
    // Tasks
    // ****
    task automatic end_of_test();
        $display("Compares %0d, errors %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            bad_count++;
            end_of_test();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        chk("read", rd & m, v);
    endtask : rdc
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            apb(1'b0, STAT, 32'h0);
            k++;
        end while ((rd & m) !== v && k < 400);
        chk("status poll", rd & m, v);
        if ((rd & m) !== v) begin
            end_of_test();
        end
    endtask : poll
    task automatic frame(input logic [4:0] n);
        nbits <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (80) @(posedge pclk);
    endtask : frame
    // ****
    // Sequence
    // ****
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        ss_n_in <= 1'b0;
        @(posedge pclk);
        rdc(CON1, 32'hFFFF_FFFF, 32'h0);
        apb(1'b1, CON1, 32'hFFFF_FFFF);
        rdc(CON1, 32'hFFFF_FFFF, 32'h1FFF);
        chk("clock pin released", sck_oe_n, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", er, 32'h1);
        apb(1'b1, CON1, 32'h20);
        apb(1'b1, BUF, 32'h5A);
        rdc(STAT, 32'h3, 32'h2);
        apb(1'b1, CTRL, 32'h1);
        chk("clock pin driven", sck_oe_n, 32'h0);
        rdc(STAT, 32'h2, 32'h0);
        poll(32'h1, 32'h1);
        apb(1'b0, BUF, 32'h0);
        rdc(STAT, 32'h1, 32'h0);
        apb(1'b1, CON1, 32'h1020);
        chk("clock pin off", sck_oe_n, 32'h1);
        // Enhanced mode, port idle while the buffer fills
        apb(1'b1, CTRL, 32'h2);
        apb(1'b1, CON1, 32'h220);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, BUF, 32'(i));
            rdc(STAT, 32'h2, (i == 3) ? 32'h2 : 32'h0);
        end
        apb(1'b1, CTRL, 32'h3);
        rdc(STAT, 32'h2, 32'h0);
        poll(32'hF000, 32'h3000);
        chk("rx flag early", rd[0], 32'h0);
        poll(32'h1, 32'h1);
        apb(1'b0, BUF, 32'h0);
        rdc(STAT, 32'h1, 32'h0);
        repeat (3) apb(1'b0, BUF, 32'h0);
        // Interrupt mask, raise and clear
        apb(1'b1, spibfc_pkg::ADDR_IRQ_EN, 32'h0);
        chk("irq masked", irq, 32'h0);
        apb(1'b1, spibfc_pkg::ADDR_IRQ_EN, 32'h2);
        chk("irq raised", irq, 32'h1);
        rdc(spibfc_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
        apb(1'b1, spibfc_pkg::ADDR_IRQ_CLR, 32'h2);
        chk("irq cleared", irq, 32'h0);
        rdc(spibfc_pkg::ADDR_IRQ_STAT, 32'h2, 32'h0);
        // Slave frames on the link clock
        apb(1'b1, CTRL, 32'h1);
        apb(1'b1, CON1, 32'h400);
        apb(1'b1, BUF, 32'h1234);
        frame(5'h08);
        rdc(STAT, 32'h1, 32'h0);
        frame(5'h08);
        rdc(STAT, 32'h1, 32'h1);
        apb(1'b1, CON1, 32'h0);
        apb(1'b0, BUF, 32'h0);
        apb(1'b1, BUF, 32'h3C);
        frame(5'h08);
        rdc(STAT, 32'h1, 32'h1);
        end_of_test();
    end
endmodule : spibfc_bench
`default_nettype wire

// >>> tb/spibfc_monitor.sv
// Checker for APB answers, control read-back and clock pin release
`timescale 1ns/1ps
`default_nettype none
module spibfc_monitor #(
    parameter int DEPTH = 4,
    parameter int HALF_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sck_out,
    input wire logic sck_oe_n
);
    // ****
    // Assertions
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence take_s;
        psel && penable && !pready;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    sequence con1_take_s;
        take_s ##0 (paddr == spibfc_pkg::ADDR_CON1);
    endsequence
    pready_pulse_a: assert property (take_s |=> answer_s)
        else $error("answer not a single pulse");
    pready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("answer without request");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error outside answer");
    unmapped_err_a: assert property (take_s ##0 (paddr > 8'h18) |=> pslverr)
        else $error("unmapped address accepted");
    upper_zero_a:
    assert property (pready && !pwrite && !pslverr |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    con1_reserved_a:
    assert property (con1_take_s ##0 !pwrite |=> prdata[15:13] == 3'h0)
        else $error("reserved control bits not zero");
    sck_release_a:
    assert property (con1_take_s ##0 (pwrite && pwdata[5] && pwdata[12]) |=> ##[0:2] sck_oe_n)
        else $error("clock pin not released");
    // Clock half period never shorter than the divider
    sck_half_a: assert property (!sck_oe_n && $changed(sck_out) |=> $stable(sck_out) [*3])
        else $error("clock half period too short");
endmodule : spibfc_monitor
bind spibfc_top spibfc_monitor #(.DEPTH(DEPTH), .HALF_DIV(HALF_DIV)) spibfc_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n));
`default_nettype wire

// >>> tb/spibfc_peer.sv
// Serial peer model: link clock for slave frames, input data pattern
`timescale 1ns/1ps
`default_nettype none
module spibfc_peer (
    input wire logic go,
    input wire logic [4:0] nbits,
    input wire logic sel_n,
    input wire logic mclk,
    output logic sck,
    output logic sdi
);
    // ****
    // Frame clock and data
    // ****
    logic [15:0] pat_q = 16'hA5C3;
    initial sck = 1'b0;
    // Clock stands still between frames
    always @(posedge go) begin
        repeat (nbits) begin
            #200 sck = 1'b1;
            #200 sck = 1'b0;
        end
    end
    always @(negedge sck or negedge mclk) pat_q <= {pat_q[14:0], ~pat_q[15]};
    // Unselected line shows the inverse, so a stale bit cannot pass
    assign sdi = sel_n ? ~pat_q[15] : pat_q[15];
endmodule : spibfc_peer
`default_nettype wire
